// ---- src/spb_burst_port.sv ----
`timescale 1ns/1ps
module spb_burst_port
    import spb_pkg::*;
#(
    parameter int DATA_W = SPB_DATA_W,
    parameter int SEL_W  = SPB_SEL_W,
    parameter int ADDR_W = SPB_ADDR_W
) (
    // Clock, reset and clock-running qualifier
    input  wire logic              i_ref_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_clk_run,
    // Command side
    input  wire logic              i_read_port_select_n,
    input  wire logic              i_write_port_select_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    // Write data side
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [SEL_W-1:0]  i_byte_write_select_n,
    // Read data side and K rise phase
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_rdata_oe_n,
    output logic                   o_k_rise
);

    localparam int IDX_W = ADDR_W + SPB_WORD_W;
    localparam int LANE_W = DATA_W / SEL_W;

    typedef struct packed {
        logic                         phase;
        spb_op_e                      last_op;
        spb_slot_s [SPB_SLOTS-1:0]    rd;
        spb_slot_s [SPB_SLOTS-1:0]    wr;
        logic [SPB_SLOTS-1:0][ADDR_W-1:0] rd_addr;
        logic [SPB_SLOTS-1:0][ADDR_W-1:0] wr_addr;
        logic                         rd_ptr;
        logic                         wr_ptr;
        logic [DATA_W-1:0]            q;
        logic                         q_oe_n;
    } spb_state_s;

    spb_state_s        st;
    spb_state_s        next_st;
    logic [DATA_W-1:0] mem [0:(2**IDX_W)-1];
    logic              start_rd;
    logic              start_wr;
    logic              wr_cap;
    logic              wr_en;
    logic              rd_drv;
    logic [IDX_W-1:0]  wr_idx;
    logic [IDX_W-1:0]  rd_idx;
    logic [3:0]        wr_off;
    logic [3:0]        rd_off;
    logic [DATA_W-1:0] wr_mask;

    // Active-low selects expanded to a bit mask, select 0 on the low lane
    function automatic logic [DATA_W-1:0] spb_mask(input logic [SEL_W-1:0] sel_n);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int b = 0; b < DATA_W; b++) begin
            m[b] = ~sel_n[b / LANE_W];
        end
        return m;
    endfunction : spb_mask

    always_comb begin
        next_st  = st;
        start_rd = 1'b0;
        start_wr = 1'b0;
        wr_cap   = 1'b0;
        wr_en    = 1'b0;
        rd_drv   = 1'b0;
        wr_idx   = '0;
        rd_idx   = '0;
        wr_off   = 4'h0;
        rd_off   = 4'h0;
        wr_mask  = spb_mask(i_byte_write_select_n);
        // With the clock stopped nothing advances and outputs keep their value
        if (i_clk_run) begin
            next_st.phase = ~st.phase;
            for (int s = 0; s < SPB_SLOTS; s++) begin
                if (st.wr[s].act) begin
                    next_st.wr[s].cnt = st.wr[s].cnt + 4'h1;
                    if (st.wr[s].cnt >= SPB_WR_FIRST) begin
                        wr_off = st.wr[s].cnt - SPB_WR_FIRST;
                        wr_cap = 1'b1;
                        wr_idx = {st.wr_addr[s], wr_off[SPB_WORD_W-1:0]};
                        wr_en  = ~&i_byte_write_select_n;
                    end
                    if (st.wr[s].cnt == SPB_WR_LAST) begin
                        next_st.wr[s].act = 1'b0;
                    end
                end
                if (st.rd[s].act) begin
                    next_st.rd[s].cnt = st.rd[s].cnt + 4'h1;
                    if (st.rd[s].cnt >= SPB_RD_FIRST) begin
                        rd_off = st.rd[s].cnt - SPB_RD_FIRST;
                        rd_drv = 1'b1;
                        rd_idx = {st.rd_addr[s], rd_off[SPB_WORD_W-1:0]};
                    end
                    if (st.rd[s].cnt == SPB_RD_LAST) begin
                        next_st.rd[s].act = 1'b0;
                    end
                end
            end
            // Bus released on the first edge with no word to launch
            next_st.q_oe_n = ~rd_drv;
            if (rd_drv) begin
                next_st.q = mem[rd_idx];
            end
            // Port selects only matter on a K rise
            if (!st.phase) begin
                start_rd = !i_read_port_select_n && (st.last_op != SPB_OP_READ);
                start_wr = !i_write_port_select_n && (st.last_op != SPB_OP_WRITE)
                           && !start_rd;
                next_st.last_op = start_rd ? SPB_OP_READ :
                                  start_wr ? SPB_OP_WRITE : SPB_OP_NONE;
                if (start_rd) begin
                    next_st.rd[st.rd_ptr].act = 1'b1;
                    next_st.rd[st.rd_ptr].cnt = SPB_CNT_START;
                    next_st.rd_addr[st.rd_ptr] = i_addr;
                    next_st.rd_ptr = ~st.rd_ptr;
                end
                if (start_wr) begin
                    next_st.wr[st.wr_ptr].act = 1'b1;
                    next_st.wr[st.wr_ptr].cnt = SPB_CNT_START;
                    next_st.wr_addr[st.wr_ptr] = i_addr;
                    next_st.wr_ptr = ~st.wr_ptr;
                end
            end
        end
        if (i_sys_rst) begin
            next_st         = '0;
            next_st.phase   = SPB_PHASE_RESET;
            next_st.last_op = SPB_OP_NONE;
            next_st.q_oe_n  = SPB_OE_N_RESET;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        st <= next_st;
    end

    // Array contents are not cleared by reset
    always_ff @(posedge i_ref_clk) begin
        if (wr_en && !i_sys_rst) begin
            mem[wr_idx] <= (mem[wr_idx] & ~wr_mask) | (i_wdata & wr_mask);
        end
    end

    assign o_rdata      = st.q;
    assign o_rdata_oe_n = st.q_oe_n;
    assign o_k_rise     = ~st.phase;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_wr_lead;
        start_wr ##1 i_clk_run [*2];
    endsequence
    sequence s_rd_lead;
        start_rd ##1 i_clk_run [*5];
    endsequence
    sequence s_burst_end;
        rd_drv ##1 (i_clk_run && !rd_drv);
    endsequence

    property p_wr_beats;
        s_wr_lead |-> wr_cap ##1 (!i_clk_run || wr_cap);
    endproperty
    a_wr_beats: assert property (p_wr_beats) else $error("write beat not captured");

    property p_rd_latency;
        s_rd_lead |=> !o_rdata_oe_n;
    endproperty
    a_rd_latency: assert property (p_rd_latency) else $error("read word late");

    property p_idle_hiz;
        (i_clk_run && i_read_port_select_n && i_write_port_select_n
         && !st.rd[0].act && !st.rd[1].act) |=> o_rdata_oe_n;
    endproperty
    a_idle_hiz: assert property (p_idle_hiz) else $error("output driven when idle");

    property p_reset_state;
        disable iff (1'b0) i_sys_rst |=> o_rdata_oe_n && o_k_rise && !wr_en;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

    property p_stop_hold;
        (!i_clk_run && !i_sys_rst) |=> $stable(o_rdata) && $stable(o_rdata_oe_n)
                                       && $stable(o_k_rise);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("outputs moved while stopped");

    property p_no_back_rd;
        start_rd ##1 (i_clk_run && !o_k_rise) ##1 (i_clk_run && !i_read_port_select_n)
            |-> !start_rd;
    endproperty
    a_no_back_rd: assert property (p_no_back_rd) else $error("back-to-back read");

    property p_no_back_wr;
        start_wr ##1 (i_clk_run && !o_k_rise) ##1 i_clk_run |-> !start_wr;
    endproperty
    a_no_back_wr: assert property (p_no_back_wr) else $error("back-to-back write");

    property p_rd_addr;
        s_rd_lead |-> rd_idx == {$past(i_addr, 5), 2'b00};
    endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("first read word not at A");

    property p_mask_none;
        (wr_cap && &i_byte_write_select_n) |-> !wr_en;
    endproperty
    a_mask_none: assert property (p_mask_none) else $error("masked beat written");

    property p_arb;
        (i_clk_run && o_k_rise && !i_read_port_select_n && !i_write_port_select_n
         && st.last_op != SPB_OP_READ) |-> start_rd && !start_wr;
    endproperty
    a_arb: assert property (p_arb) else $error("read did not win arbitration");

    property p_hiz_after;
        s_burst_end |=> o_rdata_oe_n;
    endproperty
    a_hiz_after: assert property (p_hiz_after) else $error("no release after burst");

endmodule : spb_burst_port

// ---- src/spb_pkg.sv ----
package spb_pkg;

    // Default organisation: 18-bit words, two write selects, four words per location
    localparam int SPB_DATA_W = 18;
    localparam int SPB_SEL_W  = 2;
    localparam int SPB_ADDR_W = 18;
    localparam int SPB_WORD_W = 2;
    localparam int SPB_SLOTS  = 2;

    // Beat positions counted from the command edge (beat 0, a K rise)
    localparam logic [3:0] SPB_CNT_START = 4'h1;
    localparam logic [3:0] SPB_WR_FIRST  = 4'h2;
    localparam logic [3:0] SPB_WR_LAST   = 4'h5;
    localparam logic [3:0] SPB_RD_FIRST  = 4'h5;
    localparam logic [3:0] SPB_RD_LAST   = 4'h8;

    // Values after reset
    localparam logic SPB_PHASE_RESET = 1'b0;
    localparam logic SPB_OE_N_RESET  = 1'b1;

    typedef enum logic [1:0] {
        SPB_OP_NONE,
        SPB_OP_READ,
        SPB_OP_WRITE
    } spb_op_e;

    typedef struct packed {
        logic       act;
        logic [3:0] cnt;
    } spb_slot_s;

endpackage : spb_pkg

// ---- test/spb_m.sv ----
`timescale 1ns/1ps
module spb_m
    import spb_pkg::*;
(
    // Clock and beat phase
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_k_rise,
    // Read side
    input  wire logic [SPB_DATA_W-1:0] i_rdata,
    input  wire logic                  i_rdata_oe_n,
    // Command and write side
    output logic                       o_clk_run,
    output logic                       o_rd_sel_n,
    output logic                       o_wr_sel_n,
    output logic      [SPB_ADDR_W-1:0] o_addr,
    output logic      [SPB_DATA_W-1:0] o_wdata,
    output logic      [SPB_SEL_W-1:0]  o_lane_sel_n
);
    // Pin values per beat, and what was seen after each beat
    logic                  rd [16];
    logic                  wr [16];
    logic [SPB_ADDR_W-1:0] ad [16];
    logic [SPB_DATA_W-1:0] wd [16];
    logic [SPB_SEL_W-1:0]  ln [16];
    logic [SPB_DATA_W-1:0] q  [16];
    logic                  oe [16];
    int                    hold_bad = 0;

    initial begin
        o_clk_run = 1'b1;
        o_rd_sel_n = 1'b1;
        o_wr_sel_n = 1'b1;
        o_addr = '0;
        o_wdata = '0;
        o_lane_sel_n = '1;
    end

    // Beat 0 lands on a K rise; three stopped cycles come before beat stop
    task automatic play(input int n, input int stop);
        @(negedge i_ref_clk);
        if (i_k_rise !== 1'b1) @(negedge i_ref_clk);
        for (int b = 0; b <= n; b++) begin
            if (b > 0) begin
                @(negedge i_ref_clk);
                q[b-1] = i_rdata;
                oe[b-1] = i_rdata_oe_n;
            end
            if (b == stop) begin
                o_clk_run = 1'b0;
                repeat (3) begin
                    @(negedge i_ref_clk);
                    if (i_rdata !== q[b-1] || i_rdata_oe_n !== oe[b-1]) hold_bad++;
                end
                o_clk_run = 1'b1;
            end
            o_rd_sel_n = rd[b];
            o_wr_sel_n = wr[b];
            o_addr = ad[b];
            o_wdata = wd[b];
            o_lane_sel_n = ln[b];
        end
    endtask : play
endmodule : spb_m

// ---- test/spb_burst_port_tb.sv ----
`timescale 1ns/1ps
module spb_burst_port_tb
    import spb_pkg::*;
;
    localparam int LW = SPB_DATA_W / 2;

    logic                  ref_clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  clk_run, rd_n, wr_n, oe_n, k_rise;
    logic [SPB_ADDR_W-1:0] addr, a, b;
    logic [SPB_DATA_W-1:0] wdata, rdata;
    logic [SPB_SEL_W-1:0]  ln_n;
    logic [SPB_DATA_W-1:0] mem [int];
    logic [31:0]           seed = 32'h00016c32;
    int                    error_cnt = 0;
    int                    comparisons = 0;

    initial forever #5 ref_clk = ~ref_clk;

    spb_burst_port i_spb_burst_port (
        .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_clk_run(clk_run),
        .i_read_port_select_n(rd_n), .i_write_port_select_n(wr_n), .i_addr(addr),
        .i_wdata(wdata), .i_byte_write_select_n(ln_n), .o_rdata(rdata),
        .o_rdata_oe_n(oe_n), .o_k_rise(k_rise)
    );
    spb_m i_spb_m (
        .i_ref_clk(ref_clk), .i_k_rise(k_rise), .i_rdata(rdata), .i_rdata_oe_n(oe_n),
        .o_clk_run(clk_run), .o_rd_sel_n(rd_n), .o_wr_sel_n(wr_n), .o_addr(addr),
        .o_wdata(wdata), .o_lane_sel_n(ln_n)
    );

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    // A low select bit lets its lane through
    function automatic logic [SPB_DATA_W-1:0] merge(input logic [SPB_DATA_W-1:0] o, d,
                                                    input logic [SPB_SEL_W-1:0] s);
        merge = o;
        if (!s[0]) merge[LW-1:0] = d[LW-1:0];
        if (!s[1]) merge[SPB_DATA_W-1:LW] = d[SPB_DATA_W-1:LW];
    endfunction : merge

    task automatic chk_d(input string nm, input logic [SPB_DATA_W-1:0] e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_d

    task automatic chk_b(input string nm, input logic e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_b

    // Idle selects; released lines carry changing noise
    task automatic clear();
        for (int i = 0; i < 16; i++) begin
            i_spb_m.rd[i] = 1'b1;
            i_spb_m.wr[i] = 1'b1;
            i_spb_m.ad[i] = SPB_ADDR_W'(rnd());
            i_spb_m.wd[i] = SPB_DATA_W'(rnd());
            i_spb_m.ln[i] = SPB_SEL_W'(rnd());
        end
    endtask : clear

    task automatic put_wr(input int b0, input logic [SPB_ADDR_W-1:0] wa, input logic full);
        int k;
        i_spb_m.wr[b0] = 1'b0;
        i_spb_m.ad[b0] = wa;
        for (int w = 0; w < 4; w++) begin
            k = int'({wa, 2'(w)});
            if (full) i_spb_m.ln[b0+2+w] = '0;
            mem[k] = merge(mem.exists(k) ? mem[k] : '0, i_spb_m.wd[b0+2+w],
                           i_spb_m.ln[b0+2+w]);
        end
    endtask : put_wr

    task automatic chk_rd(input int f, input logic [SPB_ADDR_W-1:0] ra);
        for (int w = 0; w < 4; w++) begin
            chk_d("rdata", mem[int'({ra, 2'(w)})], i_spb_m.q[f+w]);
            chk_b("rdata_oe_n", 1'b0, i_spb_m.oe[f+w]);
        end
    endtask : chk_rd

    task automatic give_verdict();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk_b("rdata_oe_n", 1'b1, oe_n);
        chk_b("k_rise", 1'b1, k_rise);
        chk_d("rdata", '0, rdata);
        for (int i = 0; i < 6; i++) begin
            a = SPB_ADDR_W'(rnd());
            b = {a[SPB_ADDR_W-1:1], ~a[0]};
            clear();
            put_wr(0, a, 1'b1);
            i_spb_m.play(8, 99);
            clear();
            if (i == 0) i_spb_m.ln[5] = '1;
            put_wr(0, a, 1'b0);
            i_spb_m.play(8, 99);
            clear();
            i_spb_m.rd[0] = 1'b0;
            i_spb_m.ad[0] = a;
            i_spb_m.rd[2] = 1'b0;
            i_spb_m.play(12, (i == 1) ? 6 : 99);
            chk_rd(5, a);
            chk_b("rdata_oe_n", 1'b1, i_spb_m.oe[4]);
            chk_b("rdata_oe_n", 1'b1, i_spb_m.oe[9]);
            clear();
            put_wr(0, a, 1'b1);
            i_spb_m.wr[2] = 1'b0;
            i_spb_m.ad[2] = a;
            i_spb_m.play(12, 99);
            clear();
            i_spb_m.rd[0] = 1'b0;
            i_spb_m.wr[0] = 1'b0;
            i_spb_m.ad[0] = a;
            i_spb_m.rd[2] = 1'b0;
            put_wr(2, b, 1'b1);
            i_spb_m.rd[4] = 1'b0;
            i_spb_m.wr[4] = 1'b0;
            i_spb_m.ad[4] = a;
            i_spb_m.play(14, 99);
            chk_rd(5, a);
            chk_rd(9, a);
            clear();
            i_spb_m.rd[0] = 1'b0;
            i_spb_m.ad[0] = b;
            i_spb_m.play(12, 99);
            chk_rd(5, b);
        end
        chk_b("hold", 1'b0, i_spb_m.hold_bad != 0);
        give_verdict();
    end
endmodule : spb_burst_port_tb
